/* File: hdl/lcs_pkg.sv */
package lcs_pkg;
   // Register byte offsets
   localparam logic [7:0] ADDR_CODE   = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_IRQ    = 8'h08;
   localparam logic [7:0] ADDR_MASK   = 8'h0c;
   localparam logic [7:0] ADDR_THRESH = 8'h10;
   // Transmit FIFO level codes
   localparam logic [1:0] TXL_EMPTY  = 2'h0;
   localparam logic [1:0] TXL_DATA   = 2'h1;
   localparam logic [1:0] TXL_ALMOST = 2'h2;
   localparam logic [1:0] TXL_FULL   = 2'h3;
   // Transmitter outcome codes
   localparam logic [1:0] TXO_NONE = 2'h0;
   localparam logic [1:0] TXO_UNDR = 2'h1;
   localparam logic [1:0] TXO_LOST = 2'h2;
   localparam logic [1:0] TXO_OK   = 2'h3;
   // Error category codes
   localparam logic [1:0] ERR_CRC   = 2'h0;
   localparam logic [1:0] ERR_INCMP = 2'h1;
   localparam logic [1:0] ERR_TIME  = 2'h2;
   localparam logic [1:0] ERR_BREAK = 2'h3;
   // Receive buffer head state codes
   localparam logic [2:0] RXS_EMPTY = 3'h0;
   localparam logic [2:0] RXS_DATA  = 3'h4;
   localparam logic [2:0] RXS_CC    = 3'h7;
   // Interrupt bit positions
   localparam int IRQ_FRAME = 0;
   localparam int IRQ_OVFL  = 1;
   localparam int IRQ_ERR   = 2;
   localparam int IRQ_W     = 3;
   // Reset values
   localparam logic [7:0] CODE_RESET   = 8'h00;
   localparam logic [4:0] THRESH_RESET = 5'h0c;
   // AXI response codes
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Completion code layout, MSB first
   typedef struct packed {
      logic       error;
      logic       overflow;
      logic [1:0] tx_outcome;
      logic       in_frame_resp;
      logic       resp_crc;
      logic [1:0] category;
   } lcs_code_t;

   // Frame end report from the link core
   typedef struct packed {
      logic       error;
      logic [1:0] category;
      logic [1:0] tx_outcome;
      logic       in_frame_resp;
      logic       resp_crc;
   } lcs_end_t;
endpackage

/* File: hdl/lcs_level_enc.sv */
// Transmit FIFO fill level encoder
module lcs_level_enc #(
   parameter int CNT_W = 5
) (
   input  wire logic [CNT_W-1:0] count,
   input  wire logic [CNT_W-1:0] depth,
   input  wire logic [CNT_W-1:0] almost,
   output logic      [1:0]       level
);
   // Empty, data, almost full, full
   always_comb begin
      if (count == '0)
         level = lcs_pkg::TXL_EMPTY;
      else if (count >= depth)
         level = lcs_pkg::TXL_FULL;
      else if (count >= almost)
         level = lcs_pkg::TXL_ALMOST;
      else
         level = lcs_pkg::TXL_DATA;
   end
endmodule // lcs_level_enc

/* File: hdl/lcs_top.sv */
// Overview of operation
// - Transmit FIFO level as two-bit code
// - Error flag set when frame ended erroneously
// - Overflow flag set on receive buffer overflow
// - Transmitter outcome two-bit field
// - Flag marks in-frame response
// - Response CRC flag for in-frame responses
// - Error category two-bit code
// - Code queued unless DEPTH codes are held; head state shows completion code
module lcs_top #(
   parameter int DEPTH = 16,
   parameter int CNT_W = 5
) (
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic [7:0]       s_axi_awaddr,
   input  wire logic             s_axi_awvalid,
   output logic                  s_axi_awready,
   input  wire logic [31:0]      s_axi_wdata,
   input  wire logic [3:0]       s_axi_wstrb,
   input  wire logic             s_axi_wvalid,
   output logic                  s_axi_wready,
   output logic [1:0]            s_axi_bresp,
   output logic                  s_axi_bvalid,
   input  wire logic             s_axi_bready,
   input  wire logic [7:0]       s_axi_araddr,
   input  wire logic             s_axi_arvalid,
   output logic                  s_axi_arready,
   output logic [31:0]           s_axi_rdata,
   output logic [1:0]            s_axi_rresp,
   output logic                  s_axi_rvalid,
   input  wire logic             s_axi_rready,
   input  wire logic [CNT_W-1:0] tx_count,
   input  wire logic             rx_overflow,
   input  wire logic             rx_data_head,
   input  wire logic             frame_end,
   input  wire lcs_pkg::lcs_end_t frame_info,
   output logic [1:0]            tx_fifo_level,
   output logic [2:0]            rx_buffer_state,
   output logic                  irq
);
   localparam int QW = $clog2(DEPTH);

   lcs_pkg::lcs_code_t       frame_completion_code;
   lcs_pkg::lcs_code_t       next_code;
   lcs_pkg::lcs_code_t       code_mem [DEPTH];
   logic [QW-1:0]            wr_ptr;
   logic [QW-1:0]            rd_ptr;
   logic [QW:0]              q_count;
   logic                     ovfl_seen;
   logic [CNT_W-1:0]         almost_thresh;
   logic [lcs_pkg::IRQ_W-1:0] irq_status;
   logic [lcs_pkg::IRQ_W-1:0] irq_mask;
   logic [lcs_pkg::IRQ_W-1:0] irq_set;
   logic [lcs_pkg::IRQ_W-1:0] irq_clr;
   logic [1:0]               level_now;
   logic                     aw_held;
   logic                     w_held;
   logic [7:0]               aw_addr;
   logic [31:0]              w_data;
   logic [3:0]               w_strb;
   logic                     wr_go;
   logic                     rd_go;
   logic                     pop;
   logic                     push;
   logic                     q_empty;
   logic                     q_full;
   logic                     next_aw_held;
   logic                     next_w_held;
   logic                     next_bvalid;
   logic                     next_rvalid;
   logic                     wr_map_hit;
   logic [lcs_pkg::IRQ_W-1:0] next_irq_status;
   logic [2:0]               next_rx_state;
   logic [31:0]              next_rdata;
   logic [1:0]               next_rresp;

   // Fill level encoder
   lcs_level_enc #(
      .CNT_W (CNT_W)
   ) u_level (
      .count  (tx_count),
      .depth  (CNT_W'(DEPTH)),
      .almost (almost_thresh),
      .level  (level_now)
   );

   // Register the level onto its output
   always_ff @(posedge aclk) begin
      if (!aresetn)
         tx_fifo_level <= lcs_pkg::TXL_EMPTY;
      else
         tx_fifo_level <= level_now;
   end

   // Overflow seen since the last frame end
   always_ff @(posedge aclk) begin
      if (!aresetn)
         ovfl_seen <= 1'b0;
      else if (frame_end)
         ovfl_seen <= 1'b0;
      else if (rx_overflow)
         ovfl_seen <= 1'b1;
   end

   // Build the completion code from the frame report
   always_comb begin
      next_code               = '0;
      next_code.error         = frame_info.error;
      next_code.overflow      = ovfl_seen | rx_overflow;
      next_code.tx_outcome    = frame_info.tx_outcome;
      next_code.in_frame_resp = frame_info.in_frame_resp;
      next_code.resp_crc      = frame_info.in_frame_resp & frame_info.resp_crc;
      next_code.category      = frame_info.category;
   end

   assign q_empty = (q_count == '0);
   assign q_full  = (q_count == (QW+1)'(DEPTH));
   assign push    = frame_end & ~q_full;
   assign pop     = rd_go & (s_axi_araddr == lcs_pkg::ADDR_CODE) & ~q_empty;

   // Completion code queue storage
   always_ff @(posedge aclk) begin
      if (push)
         code_mem[wr_ptr] <= next_code;
   end

   // Queue pointers and count
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_ptr  <= '0;
         rd_ptr  <= '0;
         q_count <= '0;
      end else begin
         if (push)
            wr_ptr <= wr_ptr + 1'b1;
         if (pop)
            rd_ptr <= rd_ptr + 1'b1;
         q_count <= q_count + (QW+1)'(push) - (QW+1)'(pop);
      end
   end

   // Head of queue as a register view
   always_comb begin
      if (q_empty)
         frame_completion_code = lcs_pkg::CODE_RESET;
      else
         frame_completion_code = code_mem[rd_ptr];
   end

   // Head state after this edge; a queued code hides any data byte
   always_comb begin
      if (push)
         next_rx_state = lcs_pkg::RXS_CC;
      else if (!q_empty && !(pop && q_count == (QW+1)'(1)))
         next_rx_state = lcs_pkg::RXS_CC;
      else if (rx_data_head)
         next_rx_state = lcs_pkg::RXS_DATA;
      else
         next_rx_state = lcs_pkg::RXS_EMPTY;
   end

   // Receive buffer head state
   always_ff @(posedge aclk) begin
      if (!aresetn)
         rx_buffer_state <= lcs_pkg::RXS_EMPTY;
      else
         rx_buffer_state <= next_rx_state;
   end

   // Interrupt events
   always_comb begin
      irq_set                     = '0;
      irq_set[lcs_pkg::IRQ_FRAME] = frame_end;
      irq_set[lcs_pkg::IRQ_OVFL]  = rx_overflow | (frame_end & q_full);
      irq_set[lcs_pkg::IRQ_ERR]   = frame_end & frame_info.error;
   end

   // Write-one-to-clear mask from the bus
   always_comb begin
      irq_clr = '0;
      if (wr_go && aw_addr == lcs_pkg::ADDR_IRQ && w_strb[0])
         irq_clr = w_data[lcs_pkg::IRQ_W-1:0];
   end

   // Status after this edge; an event in the clearing cycle wins
   assign next_irq_status = (irq_status & ~irq_clr) | irq_set;

   // Sticky status
   always_ff @(posedge aclk) begin
      if (!aresetn)
         irq_status <= '0;
      else
         irq_status <= next_irq_status;
   end

   // Interrupt output, high while an unmasked bit is set
   always_ff @(posedge aclk) begin
      if (!aresetn)
         irq <= 1'b0;
      else
         irq <= |(next_irq_status & irq_mask);
   end

   // Write address and data capture, either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_addr <= '0;
         w_data  <= '0;
         w_strb  <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_held <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (wr_go) begin
            w_held <= 1'b0;
         end
      end
   end

   assign wr_go = aw_held & w_held & ~s_axi_bvalid;

   // Held items and answers as they will stand after this edge
   always_comb begin
      next_aw_held = aw_held;
      next_w_held  = w_held;
      next_bvalid  = s_axi_bvalid;
      next_rvalid  = s_axi_rvalid;
      if (s_axi_awvalid && s_axi_awready)
         next_aw_held = 1'b1;
      else if (wr_go)
         next_aw_held = 1'b0;
      if (s_axi_wvalid && s_axi_wready)
         next_w_held = 1'b1;
      else if (wr_go)
         next_w_held = 1'b0;
      if (wr_go)
         next_bvalid = 1'b1;
      else if (s_axi_bready)
         next_bvalid = 1'b0;
      if (rd_go)
         next_rvalid = 1'b1;
      else if (s_axi_rready)
         next_rvalid = 1'b0;
   end

   // Readies come from flops, ready while nothing is held or pending
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_arready <= 1'b1;
      end else begin
         s_axi_awready <= ~next_aw_held & ~next_bvalid;
         s_axi_wready  <= ~next_w_held & ~next_bvalid;
         s_axi_arready <= ~next_rvalid;
      end
   end

   // Writable registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_mask      <= '0;
         almost_thresh <= lcs_pkg::THRESH_RESET;
      end else if (wr_go && w_strb[0]) begin
         if (aw_addr == lcs_pkg::ADDR_MASK)
            irq_mask <= w_data[lcs_pkg::IRQ_W-1:0];
         if (aw_addr == lcs_pkg::ADDR_THRESH)
            almost_thresh <= w_data[CNT_W-1:0];
      end
   end

   // Write offset decode; read-only offsets still answer okay
   always_comb begin
      wr_map_hit = 1'b0;
      case (aw_addr)
         lcs_pkg::ADDR_CODE,
         lcs_pkg::ADDR_STATUS,
         lcs_pkg::ADDR_IRQ,
         lcs_pkg::ADDR_MASK,
         lcs_pkg::ADDR_THRESH: wr_map_hit = 1'b1;
         default:              wr_map_hit = 1'b0;
      endcase
   end

   // Write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= lcs_pkg::RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         if (wr_map_hit)
            s_axi_bresp <= lcs_pkg::RESP_OKAY;
         else
            s_axi_bresp <= lcs_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   assign rd_go = s_axi_arvalid & s_axi_arready;

   // Read word for the requested offset; unmapped offsets answer an error
   always_comb begin
      next_rdata = 32'h0000_0000;
      next_rresp = lcs_pkg::RESP_OKAY;
      case (s_axi_araddr)
         lcs_pkg::ADDR_CODE:
            next_rdata = {24'h00_0000, frame_completion_code};
         lcs_pkg::ADDR_STATUS:
            next_rdata = {27'h000_0000, rx_buffer_state, tx_fifo_level};
         lcs_pkg::ADDR_IRQ:
            next_rdata = {29'h0000_0000, irq_status};
         lcs_pkg::ADDR_MASK:
            next_rdata = {29'h0000_0000, irq_mask};
         lcs_pkg::ADDR_THRESH:
            next_rdata = {27'h000_0000, almost_thresh};
         default:
            next_rresp = lcs_pkg::RESP_SLVERR;
      endcase
   end

   // Read answer; reading the code register pops the queue
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= lcs_pkg::RESP_OKAY;
      end else if (rd_go) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= next_rdata;
         s_axi_rresp  <= next_rresp;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule // lcs_top

/* File: test/lcs_top_checker.sv */
// Port-level checks on level codes, head state and bus answers
module lcs_top_checker #(
   parameter int DEPTH = 16,
   parameter int CNT_W = 5
) (
   input wire logic             aclk,
   input wire logic             aresetn,
   input wire logic [CNT_W-1:0] tx_count,
   input wire logic             frame_end,
   input wire logic             rx_data_head,
   input wire logic [1:0]       tx_fifo_level,
   input wire logic [2:0]       rx_buffer_state,
   input wire logic             s_axi_arvalid,
   input wire logic             s_axi_arready,
   input wire logic             s_axi_rvalid,
   input wire logic             s_axi_rready,
   input wire logic             s_axi_bvalid,
   input wire logic             s_axi_bready
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int THR = 12;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Level code follows the occupancy one cycle later
   chk_level_empty: assert property (tx_count == 0 |=> tx_fifo_level == 2'h0)
      else $error("level code wrong for empty");
   chk_level_data: assert property (tx_count != 0 && tx_count < THR |=> tx_fifo_level == 2'h1)
      else $error("level code wrong for data");
   chk_level_full: assert property (tx_count >= DEPTH |=> tx_fifo_level == 2'h3)
      else $error("level code wrong for full");
   // A code shows at the head the cycle after each frame end
   chk_head_code: assert property (frame_end |=> rx_buffer_state == 3'h7)
      else $error("head state misses completion code");
   chk_head_data: assert property (!frame_end && rx_buffer_state == 3'h0 && rx_data_head
      |=> rx_buffer_state == 3'h4) else $error("head state misses data byte");
   // Bus answers come and go on time
   chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   chk_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
   chk_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read answer not released");
   chk_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write answer not released");
endmodule // lcs_top_checker

bind lcs_top lcs_top_checker #(.DEPTH(DEPTH), .CNT_W(CNT_W)) chk_i (.aclk, .aresetn,
   .tx_count, .frame_end, .rx_data_head, .tx_fifo_level, .rx_buffer_state, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid, .s_axi_bready);

/* File: test/lcs_link_model.sv */
// Link core stand-in that reports frame ends
module lcs_link_model (
   input  wire logic         aclk,
   output logic              frame_end,
   output lcs_pkg::lcs_end_t frame_info,
   output logic              rx_overflow
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      frame_end = 1'b0;
      frame_info = '0;
      rx_overflow = 1'b0;
   end
   // Overflow pulse inside the frame, then a one-cycle end report
   task automatic send(input lcs_pkg::lcs_end_t info, input logic ovf);
      rx_overflow <= ovf;
      @(posedge aclk);
      frame_end <= 1'b1;
      frame_info <= info;
      rx_overflow <= 1'b0;
      @(posedge aclk);
      frame_end <= 1'b0;
      frame_info <= ~info;
      @(posedge aclk);
   endtask
endmodule // lcs_link_model

/* File: test/tb_link_completion_status.sv */
module tb_link_completion_status;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
   logic frame_end, rx_overflow, rx_data_head, ov;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, eirq;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, tx_fifo_level, r;
   logic [2:0]  rx_buffer_state;
   logic [4:0]  tx_count;
   lcs_pkg::lcs_end_t frame_info, fi;
   int num_errors, n_tests, seed, v;
   int lv[6] = '{0, 1, 11, 12, 15, 16};
   logic [7:0] exp_q[$];
   lcs_top #(.DEPTH(16), .CNT_W(5)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_count, .rx_overflow, .rx_data_head,
      .frame_end, .frame_info, .tx_fifo_level, .rx_buffer_state, .irq);
   lcs_link_model link (.aclk, .frame_end, .frame_info, .rx_overflow);
   // Clock at 20 MHz
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end
   function automatic logic [1:0] exp_lvl(int c);
      if (c >= 16) return 2'h3;
      if (c >= 12) return 2'h2;
      return (c == 0) ? 2'h0 : 2'h1;
   endfunction
   function automatic logic [7:0] exp_code(lcs_pkg::lcs_end_t f, logic o);
      return {f.error, o, f.tx_outcome, f.in_frame_resp, f.in_frame_resp & f.resp_crc, f.category};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Write: address and data offered together, each released once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] wd);
      logic ta, tw, tb;
      s_axi_awaddr <= a;
      s_axi_wdata <= wd;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      tb = 1'b0;
      while (!tb) begin
         @(negedge aclk);
         ta = s_axi_awvalid & s_axi_awready;
         tw = s_axi_wvalid & s_axi_wready;
         tb = s_axi_bvalid & s_axi_bready;
         r = s_axi_bresp;
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic rd(input logic [7:0] a);
      logic ta, tr;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      tr = 1'b0;
      while (!tr) begin
         @(negedge aclk);
         ta = s_axi_arvalid & s_axi_arready;
         tr = s_axi_rvalid & s_axi_rready;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge aclk);
         if (ta) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic stop_test;
      $display("errors %0d of %0d checks", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge aclk);
      num_errors++;
      stop_test();
   end
   // Main sequence
   initial begin
      seed = 32'h9ce6;
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, tx_count, rx_data_head, eirq} = '0;
      s_axi_wstrb = 4'hf;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (int i = 0; i < 12; i++) begin
         v = (i < 6) ? lv[i] : ($random(seed) & 31);
         tx_count <= 5'(v);
         repeat (2) @(posedge aclk);
         chk(tx_fifo_level, exp_lvl(v));
      end
      // Raised almost-full mark, read back, then restored
      wr(lcs_pkg::ADDR_THRESH, 32'h0000_000e);
      rd(lcs_pkg::ADDR_THRESH);
      chk(d, 32'h0000_000e);
      tx_count <= 5'h0d;
      repeat (2) @(posedge aclk);
      chk(tx_fifo_level, lcs_pkg::TXL_DATA);
      wr(lcs_pkg::ADDR_THRESH, 32'h0000_000c);
      wr(lcs_pkg::ADDR_MASK, 32'h0000_0007);
      // Frames in pairs, every outcome and category code
      for (int i = 0; i < 8; i++) begin
         fi = lcs_pkg::lcs_end_t'($random(seed));
         fi.tx_outcome = 2'(i);
         fi.category = 2'(i);
         fi.error = i[2] ^ i[0];
         if (i < 4) begin
            fi.in_frame_resp = i[1];
            fi.resp_crc = i[0];
         end
         ov = i[1];
         link.send(fi, ov);
         exp_q.push_back(exp_code(fi, ov));
         eirq = eirq | {5'h00, fi.error, ov, 1'b1};
         if (i[0]) begin
            chk({irq, rx_buffer_state}, 4'hf);
            rd(lcs_pkg::ADDR_IRQ);
            chk(d, {24'h0, eirq});
            wr(lcs_pkg::ADDR_IRQ, {24'h0, eirq});
            eirq = 8'h00;
            repeat (2) begin
               rd(lcs_pkg::ADDR_CODE);
               chk(d, {24'h0, exp_q.pop_front()});
            end
            chk({irq, rx_buffer_state}, 4'h0);
         end
      end
      // Empty code read, ignored write, unmapped read, masked event
      rd(lcs_pkg::ADDR_CODE);
      chk(d, 32'h0000_0000);
      wr(lcs_pkg::ADDR_CODE, 32'h0000_00ff);
      chk(r, lcs_pkg::RESP_OKAY);
      rd(8'h20);
      chk(r, lcs_pkg::RESP_SLVERR);
      chk(d, 32'h0000_0000);
      wr(lcs_pkg::ADDR_MASK, 32'h0000_0000);
      fi = '0;
      fi.error = 1'b1;
      link.send(fi, 1'b0);
      chk(irq, 1'b0);
      rx_data_head <= 1'b1;
      rd(lcs_pkg::ADDR_CODE);
      chk(d, {24'h0, exp_code(fi, 1'b0)});
      @(posedge aclk);
      chk(rx_buffer_state, 3'h4);
      stop_test();
   end
endmodule // tb_link_completion_status
